// file: rss_defs.vh
`ifndef RSS_DEFS_VH
`define RSS_DEFS_VH
// clock rate in cycles per microsecond
`define RSS_CLK_PER_US 100
// register byte offsets
`define RSS_OFF_HARDWARE_CONFIG 32'h00000000
`define RSS_OFF_PMT 32'h00000004
`define RSS_OFF_E2P 32'h00000008
`define RSS_OFF_PHY_BCR 32'h0000000c
`define RSS_OFF_WAKE 32'h00000010
`define RSS_OFF_STAT 32'h00000014
// field positions
`define RSS_SOFT_RESET_BIT 0
`define RSS_READY_BIT 0
`define RSS_PHY_RST_BIT 10
`define RSS_PM_MODE_LO 12
`define RSS_PM_MODE_HI 13
`define RSS_E2P_BUSY_BIT 31
`define RSS_PHY_BCR_RST_BIT 15
// reset values
`define RSS_PM_MODE_RST 2'h0
// times in microseconds, as specified
`define RSS_POR_US 22000
`define RSS_SOFT_US 2
`define RSS_PHY_US 100
`define RSS_WAKE_US 2000
// hold after the pin is released, in cycles
`define RSS_HARD_HOLD 16
// axi responses
`define RSS_RESP_OKAY 2'h0
`define RSS_RESP_SLVERR 2'h2
`endif

// file: rss_host.sv
`timescale 1ns/1ns
`include "rss_defs.vh"
// host cpu model, axi4-lite master
module rss_host (
  // clock
  input wire sys_clk,
  // write channels
  output logic [31:0] awaddr,
  output logic awvalid,
  input wire awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire wready,
  input wire [1:0] bresp,
  input wire bvalid,
  output logic bready,
  // read channels
  output logic [31:0] araddr,
  output logic arvalid,
  input wire arready,
  input wire [31:0] rdata,
  input wire [1:0] rresp,
  input wire rvalid,
  output logic rready
);
  // idle bus at time zero
  initial begin
    {awaddr, wdata, araddr} = 96'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    wstrb = 4'h0;
  end
  // one write, address and data offered together
  task automatic wr(input logic [31:0] a, input logic [31:0] v, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
  // one read
  task automatic rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        v = rdata;
        r = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
  // poll the ready flag with reads only, give up after a bounded wait
  task automatic wait_ready(output logic ok);
    logic [31:0] v;
    logic [1:0] r;
    integer i;
    ok = 1'b0;
    for (i = 0; i < 200 && !ok; i++) begin
      rd(`RSS_OFF_PMT, v, r);
      ok = (v[`RSS_READY_BIT] === 1'b1);
    end
  endtask
endmodule

// file: rss_pin_sync.v
`timescale 1ns/1ns
// three-stage synchroniser with agreement filter for the reset pin
module rss_pin_sync (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  // raw pin level and its clean copy
  input wire pin_in,
  output reg pin_out
);
  reg meta_reg; // first stage, read only by the second
  reg s2_reg; // second stage
  reg s3_reg; // third stage

  // stages reset high so an idle pin never looks asserted
  always @(posedge sys_clk) begin
    if (rst) begin
      meta_reg <= 1'b1;
      s2_reg <= 1'b1;
      s3_reg <= 1'b1;
      pin_out <= 1'b1;
    end else begin
      meta_reg <= pin_in;
      s2_reg <= meta_reg;
      s3_reg <= s2_reg;
      // change only once stages two and three agree
      if (s2_reg == s3_reg) begin
        pin_out <= s3_reg;
      end
    end
  end
endmodule

// file: rss_reset_seq.v
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ns
`include "rss_defs.vh"
// Operation
// - accept five reset sources
// - power-on and pin reset hit everything
// - soft reset spares pll, phy, straps, kept regs
// - phy-only resets touch only the phy
// - probe eeprom after full/soft reset, busy set
// - power-on timer holds reset about 22 ms
// - ready reads 0 until power-on done
// - pin low resets; ready 0 until done
// - pin idles high, never resets unconnected
// - ready set within 2 ms of wake
// - soft bit self-clears after 2 us, ready
// - phy bit self-clears after about 100 us
// - phy control bit self-clears when done
module rss_reset_seq #(
  parameter integer POR_CYCLES = `RSS_POR_US * `RSS_CLK_PER_US,
  parameter integer PHY_CYCLES = `RSS_PHY_US * `RSS_CLK_PER_US,
  parameter integer WAKE_CYCLES = `RSS_WAKE_US * `RSS_CLK_PER_US
) (
  // clock and power-on reset
  input wire sys_clk,
  input wire rst,
  // hardware reset pin, active low
  input wire hard_reset_pin_n,
  // eeprom probe finished, one-cycle pulse
  input wire eeprom_done,
  // reset outputs to the circuitry
  output reg pll_reset,
  output reg host_bus_reset,
  output reg kept_regs_reset,
  output reg mac_if_reset,
  output reg mac_reset,
  output reg phy_reset,
  output reg eeprom_reload,
  output reg strap_latch,
  // axi4-lite write address
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  localparam integer SOFT_CYCLES = `RSS_SOFT_US * `RSS_CLK_PER_US;
  // sequencer states
  localparam [2:0] ST_POR = 3'h0;
  localparam [2:0] ST_HARD = 3'h1;
  localparam [2:0] ST_SOFT = 3'h2;
  localparam [2:0] ST_RUN = 3'h3;
  localparam [2:0] ST_SLEEP = 3'h4;
  localparam [2:0] ST_WAKE = 3'h5;
  // register indices from decode
  localparam [2:0] RG_NONE = 3'h0;
  localparam [2:0] RG_HW = 3'h1;
  localparam [2:0] RG_PMT = 3'h2;
  localparam [2:0] RG_E2P = 3'h3;
  localparam [2:0] RG_BCR = 3'h4;
  localparam [2:0] RG_WAKE = 3'h5;
  localparam [2:0] RG_STAT = 3'h6;

  // address decode, shared by read and write paths
  function [2:0] rss_decode;
    input [31:0] addr;
    begin
      if (addr == `RSS_OFF_HARDWARE_CONFIG) begin
        rss_decode = RG_HW;
      end else if (addr == `RSS_OFF_PMT) begin
        rss_decode = RG_PMT;
      end else if (addr == `RSS_OFF_E2P) begin
        rss_decode = RG_E2P;
      end else if (addr == `RSS_OFF_PHY_BCR) begin
        rss_decode = RG_BCR;
      end else if (addr == `RSS_OFF_WAKE) begin
        rss_decode = RG_WAKE;
      end else if (addr == `RSS_OFF_STAT) begin
        rss_decode = RG_STAT;
      end else begin
        rss_decode = RG_NONE;
      end
    end
  endfunction

  wire pin_n_clean; // filtered pin level
  reg [2:0] state_reg; // sequencer state
  reg [2:0] state_next;
  reg [31:0] cnt_reg; // sequencer timer
  reg [31:0] cnt_next;
  reg ready_reg; // ready flag shown to the host
  reg [1:0] pm_mode_reg; // requested power mode
  reg e2p_busy_reg; // eeprom probe in progress
  reg phy_pmt_busy_reg; // phy reset from power control bit
  reg phy_bcr_busy_reg; // phy reset from phy control bit
  reg [31:0] phy_cnt_reg; // phy reset timer
  reg [31:0] aw_addr_reg; // held write address
  reg aw_full_reg; // write address held
  reg [31:0] w_data_reg; // held write data
  reg [3:0] w_strb_reg; // held write strobes
  reg w_full_reg; // write data held
  wire wr_fire; // both halves present, response free
  wire [2:0] wr_sel; // decoded write target
  wire wr_ok; // writes allowed only while ready
  wire soft_req; // soft reset requested
  wire sleep_req; // power mode change requested
  wire wake_req; // wake register written
  wire phy_pmt_req; // phy reset via power control
  wire phy_bcr_req; // phy reset via phy control
  wire full_done; // power-on or pin reset finishing
  wire soft_done; // soft reset finishing
  wire in_full; // power-on or pin reset in progress

  // pin filter; stages reset high, acting as the internal pull-up
  rss_pin_sync u_pin_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin_in(hard_reset_pin_n),
    .pin_out(pin_n_clean)
  );

  // write channel decode; writes other than wake ignored while not ready
  assign wr_fire = aw_full_reg & w_full_reg & ~s_axi_bvalid;
  assign wr_sel = rss_decode(aw_addr_reg);
  assign wr_ok = wr_fire & ready_reg & (state_reg == ST_RUN);
  assign soft_req = wr_ok & (wr_sel == RG_HW) & w_strb_reg[0] &
    w_data_reg[`RSS_SOFT_RESET_BIT];
  assign phy_pmt_req = wr_ok & (wr_sel == RG_PMT) & w_strb_reg[1] &
    w_data_reg[`RSS_PHY_RST_BIT];
  assign sleep_req = wr_ok & (wr_sel == RG_PMT) & w_strb_reg[1] &
    (w_data_reg[`RSS_PM_MODE_HI:`RSS_PM_MODE_LO] != 2'h0);
  assign phy_bcr_req = wr_ok & (wr_sel == RG_BCR) & w_strb_reg[1] &
    w_data_reg[`RSS_PHY_BCR_RST_BIT];
  // any data to the wake register wakes, even without ready
  assign wake_req = wr_fire & (wr_sel == RG_WAKE) & (state_reg == ST_SLEEP);
  assign in_full = (state_reg == ST_POR) | (state_reg == ST_HARD);

  // sequencer next state; a low pin overrides every other source
  always @* begin
    state_next = state_reg;
    cnt_next = cnt_reg + 32'h1;
    if (!pin_n_clean) begin
      // hold while the pin is low, timing restarts on release
      state_next = ST_HARD;
      cnt_next = 32'h0;
    end else begin
      case (state_reg)
        ST_POR: begin
          if (cnt_reg >= POR_CYCLES - 1) begin
            state_next = ST_RUN;
          end
        end
        ST_HARD: begin
          // released only after the filtered pin has stayed high
          if (cnt_reg >= `RSS_HARD_HOLD - 1) begin
            state_next = ST_RUN;
          end
        end
        ST_SOFT: begin
          if (cnt_reg >= SOFT_CYCLES - 1) begin
            state_next = ST_RUN;
          end
        end
        ST_RUN: begin
          cnt_next = 32'h0;
          if (soft_req) begin
            state_next = ST_SOFT;
          end else if (sleep_req) begin
            state_next = ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          cnt_next = 32'h0;
          if (wake_req) begin
            state_next = ST_WAKE;
          end
        end
        ST_WAKE: begin
          // fixed delay no longer than the promised bound
          if (cnt_reg >= WAKE_CYCLES - 1) begin
            state_next = ST_RUN;
          end
        end
        default: begin
          state_next = ST_POR;
          cnt_next = 32'h0;
        end
      endcase
    end
    if (state_next != state_reg) begin
      cnt_next = 32'h0;
    end
  end

  assign full_done = in_full & (state_next == ST_RUN);
  assign soft_done = (state_reg == ST_SOFT) & (state_next == ST_RUN);

  // sequencer state, ready flag and power mode
  always @(posedge sys_clk) begin
    if (rst) begin
      // power-on starts here and owns the timer
      state_reg <= ST_POR;
      cnt_reg <= 32'h0;
      ready_reg <= 1'b0;
      pm_mode_reg <= `RSS_PM_MODE_RST;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      // ready only in run; cleared by power-on, pin and soft resets and by sleep, kept through phy-only resets
      ready_reg <= (state_next == ST_RUN);
      if (sleep_req) begin
        pm_mode_reg <= w_data_reg[`RSS_PM_MODE_HI:`RSS_PM_MODE_LO];
      end else if (state_next != ST_SLEEP) begin
        // any wake or reset returns the mode field to normal
        pm_mode_reg <= `RSS_PM_MODE_RST;
      end
    end
  end

  // phy-only resets; a full reset also clears them
  always @(posedge sys_clk) begin
    if (rst) begin
      phy_pmt_busy_reg <= 1'b0;
      phy_bcr_busy_reg <= 1'b0;
      phy_cnt_reg <= 32'h0;
    end else if (in_full) begin
      phy_pmt_busy_reg <= 1'b0;
      phy_bcr_busy_reg <= 1'b0;
      phy_cnt_reg <= 32'h0;
    end else begin
      if (phy_pmt_req | phy_bcr_req) begin
        // a second request restarts the timer rather than stacking
        phy_cnt_reg <= 32'h0;
        if (phy_pmt_req) begin
          phy_pmt_busy_reg <= 1'b1;
        end
        if (phy_bcr_req) begin
          phy_bcr_busy_reg <= 1'b1;
        end
      end else if (phy_pmt_busy_reg | phy_bcr_busy_reg) begin
        if (phy_cnt_reg >= PHY_CYCLES - 1) begin
          phy_pmt_busy_reg <= 1'b0;
          phy_bcr_busy_reg <= 1'b0;
          phy_cnt_reg <= 32'h0;
        end else begin
          phy_cnt_reg <= phy_cnt_reg + 32'h1;
        end
      end
    end
  end

  // eeprom busy flag; a new probe wins over a done in the same cycle
  always @(posedge sys_clk) begin
    if (rst) begin
      e2p_busy_reg <= 1'b0;
    end else if (full_done | soft_done) begin
      e2p_busy_reg <= 1'b1;
    end else if (eeprom_done | in_full) begin
      e2p_busy_reg <= 1'b0;
    end
  end

  // reset routing, registered so every output is a flip-flop
  always @(posedge sys_clk) begin
    if (rst) begin
      pll_reset <= 1'b1;
      host_bus_reset <= 1'b1;
      kept_regs_reset <= 1'b1;
      mac_if_reset <= 1'b1;
      mac_reset <= 1'b1;
      phy_reset <= 1'b1;
      eeprom_reload <= 1'b0;
      strap_latch <= 1'b0;
    end else begin
      // pll and kept registers only see power-on and pin resets
      pll_reset <= (state_next == ST_POR) | (state_next == ST_HARD);
      kept_regs_reset <= (state_next == ST_POR) |
        (state_next == ST_HARD);
      // bus, mac layer and mac also follow soft reset
      host_bus_reset <= (state_next == ST_POR) | (state_next == ST_HARD) |
        (state_next == ST_SOFT);
      mac_if_reset <= (state_next == ST_POR) | (state_next == ST_HARD) |
        (state_next == ST_SOFT);
      mac_reset <= (state_next == ST_POR) | (state_next == ST_HARD) |
        (state_next == ST_SOFT);
      // phy follows full resets and its own two sources only
      phy_reset <= (state_next == ST_POR) | (state_next == ST_HARD) |
        phy_pmt_busy_reg | phy_bcr_busy_reg | phy_pmt_req |
        phy_bcr_req;
      // reload after full and soft resets, straps after full only
      eeprom_reload <= full_done | soft_done;
      strap_latch <= full_done;
    end
  end

  // write address and data are taken independently
  always @(posedge sys_clk) begin
    if (rst) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_addr_reg <= 32'h0;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RSS_RESP_OKAY;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      // ready drops when a half is held, returns after the response
      s_axi_awready <= ~(aw_full_reg | (s_axi_awvalid & s_axi_awready));
      s_axi_wready <= ~(w_full_reg | (s_axi_wvalid & s_axi_wready));
      if (wr_fire) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // unmapped offsets answer slverr; gated writes still answer okay
        s_axi_bresp <= (wr_sel == RG_NONE) ? `RSS_RESP_SLVERR : `RSS_RESP_OKAY;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read channel: one read in flight, answer one cycle after the take
  always @(posedge sys_clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `RSS_RESP_OKAY;
    end else begin
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `RSS_RESP_OKAY;
        s_axi_rdata <= 32'h0;
        case (rss_decode(s_axi_araddr))
          RG_HW: begin
            // soft bit reads 1 until the soft reset ends
            s_axi_rdata[`RSS_SOFT_RESET_BIT] <= (state_reg == ST_SOFT);
          end
          RG_PMT: begin
            s_axi_rdata[`RSS_READY_BIT] <= ready_reg;
            s_axi_rdata[`RSS_PHY_RST_BIT] <= phy_pmt_busy_reg;
            s_axi_rdata[`RSS_PM_MODE_HI:`RSS_PM_MODE_LO] <= pm_mode_reg;
          end
          RG_E2P: begin
            s_axi_rdata[`RSS_E2P_BUSY_BIT] <= e2p_busy_reg;
          end
          RG_BCR: begin
            s_axi_rdata[`RSS_PHY_BCR_RST_BIT] <= phy_bcr_busy_reg;
          end
          RG_WAKE: begin
            s_axi_rdata <= 32'h0;
          end
          RG_STAT: begin
            s_axi_rdata[2:0] <= state_reg;
            s_axi_rdata[8] <= pll_reset;
            s_axi_rdata[9] <= host_bus_reset;
            s_axi_rdata[10] <= mac_reset;
            s_axi_rdata[11] <= phy_reset;
          end
          default: begin
            s_axi_rresp <= `RSS_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule

// file: rss_reset_seq_bench.sv
`timescale 1ns/1ns
`include "rss_defs.vh"
module rss_reset_seq_bench;
  // shortened counts
  localparam integer POR = 50;
  localparam integer PHY = 20;
  localparam integer WAKE = 30;
  // stimulus and observed pins
  logic sys_clk, rst, hard_reset_pin_n, eeprom_done;
  wire pll_reset, host_bus_reset, kept_regs_reset, mac_if_reset, mac_reset, phy_reset;
  wire eeprom_reload, strap_latch;
  wire [31:0] awaddr, wdata, araddr, rdata;
  wire [3:0] wstrb;
  wire [1:0] bresp, rresp;
  wire awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  // bookkeeping
  integer error_cnt = 0, samples_checked = 0, strap_n = 0, reload_n = 0, n, k, b;
  time t0;
  logic [31:0] d, a;
  logic [1:0] r;
  logic ok;
  rss_reset_seq #(.POR_CYCLES(POR), .PHY_CYCLES(PHY), .WAKE_CYCLES(WAKE)) dut (
    .sys_clk(sys_clk), .rst(rst), .hard_reset_pin_n(hard_reset_pin_n),
    .eeprom_done(eeprom_done), .pll_reset(pll_reset), .host_bus_reset(host_bus_reset),
    .kept_regs_reset(kept_regs_reset), .mac_if_reset(mac_if_reset), .mac_reset(mac_reset),
    .phy_reset(phy_reset), .eeprom_reload(eeprom_reload), .strap_latch(strap_latch),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  rss_host host (
    .sys_clk(sys_clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  // 100 mhz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // count end-of-reset pulses
  always @(posedge sys_clk) begin
    if (strap_latch === 1'b1) strap_n <= strap_n + 1;
    if (eeprom_reload === 1'b1) reload_n <= reload_n + 1;
  end
  task print_verdict;
    if (error_cnt == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
      error_cnt++;
    end
  endtask
  // cycles until a reset output drops: 0 pll, 1 host bus, 2 phy
  task cnt_hi(input integer s);
    n = 0;
    do begin
      @(negedge sys_clk);
      n = n + 1;
    end while (n < 5000 && (s == 0 ? pll_reset : s == 1 ? host_bus_reset : phy_reset) === 1'b1);
  endtask
  // eeprom probe finishes
  task probe_done;
    @(posedge sys_clk) eeprom_done <= 1'b1;
    @(posedge sys_clk) eeprom_done <= 1'b0;
  endtask
  // hang guard, far beyond the expected run
  initial begin
    #300000;
    error_cnt++;
    print_verdict;
  end
  initial begin
    rst = 1'b1;
    hard_reset_pin_n = 1'b1; // pin left high as if unconnected
    eeprom_done = 1'b0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    t0 = $time;
    host.rd(`RSS_OFF_PMT, d, r);
    chk(d[0], 0);
    cnt_hi(0);
    n = (($time - t0) / 10);
    chk(n >= POR - 1 && n <= POR + 4, 1);
    host.wait_ready(ok);
    chk(ok, 1);
    chk(strap_n, 1);
    host.rd(`RSS_OFF_E2P, d, r);
    chk(d[31], 1);
    probe_done;
    host.rd(`RSS_OFF_E2P, d, r);
    chk(d[31], 0);
    // soft reset spares pll, kept registers and phy
    host.wr(`RSS_OFF_HARDWARE_CONFIG, 32'h1, r);
    chk({pll_reset, kept_regs_reset, phy_reset}, 3'h0);
    chk({host_bus_reset, mac_if_reset, mac_reset}, 3'h7);
    host.rd(`RSS_OFF_HARDWARE_CONFIG, d, r);
    chk(d[0], 1);
    // status: soft state, bus and mac in reset, pll and phy spared
    host.rd(`RSS_OFF_STAT, d, r);
    chk(d, 32'h00000602);
    cnt_hi(1);
    chk(n >= 188 && n <= 200, 1);
    host.rd(`RSS_OFF_HARDWARE_CONFIG, d, r);
    chk(d[0], 0);
    host.rd(`RSS_OFF_PMT, d, r);
    chk(d[0], 1);
    chk({strap_n[7:0], reload_n[7:0]}, 16'h0102);
    probe_done;
    // both phy-only sources
    for (k = 0; k < 2; k++) begin
      a = k ? `RSS_OFF_PHY_BCR : `RSS_OFF_PMT;
      b = k ? `RSS_PHY_BCR_RST_BIT : `RSS_PHY_RST_BIT;
      host.wr(a, 32'h1 << b, r);
      @(negedge sys_clk);
      chk({pll_reset, host_bus_reset, phy_reset}, 3'h1);
      host.rd(a, d, r);
      chk(d[b], 1);
      cnt_hi(2);
      chk(n >= PHY - 10 && n <= PHY, 1);
      host.rd(a, d, r);
      chk(d[b], 0);
      chk(reload_n, 2);
    end
    // sleep, then wake through the wake register
    host.wr(`RSS_OFF_PMT, 32'h1000, r);
    host.rd(`RSS_OFF_PMT, d, r);
    chk(d[13:0], 14'h1000);
    host.wr(`RSS_OFF_WAKE, 32'h0, r);
    t0 = $time;
    host.wait_ready(ok);
    chk(ok && ($time - t0) / 10 <= WAKE + 10, 1);
    // hardware pin reset
    @(posedge sys_clk) hard_reset_pin_n <= 1'b0;
    repeat (10) @(negedge sys_clk);
    chk({pll_reset, kept_regs_reset, host_bus_reset, phy_reset}, 4'hf);
    host.rd(`RSS_OFF_PMT, d, r);
    chk(d[0], 0);
    @(posedge sys_clk) hard_reset_pin_n <= 1'b1;
    repeat (8) @(negedge sys_clk);
    chk(pll_reset, 1);
    host.wait_ready(ok);
    chk(ok, 1);
    chk({strap_n[7:0], reload_n[7:0]}, 16'h0203);
    host.rd(`RSS_OFF_E2P, d, r);
    chk(d[31], 1);
    probe_done;
    // unmapped place answers with an error
    host.rd(32'h40, d, r);
    chk(r, `RSS_RESP_SLVERR);
    host.wr(32'h40, 32'h0, r);
    chk(r, `RSS_RESP_SLVERR);
    print_verdict;
  end
endmodule

// file: rss_reset_seq_chk.sv
`timescale 1ns/1ns
// watches the reset outputs of the sequencer from its pins only
module rss_chk #(
  parameter integer POR_CYCLES = 50
) (
  // clock and power-on reset
  input wire sys_clk,
  input wire rst,
  // raw reset pin
  input wire hard_reset_pin_n,
  // reset outputs
  input wire pll_reset,
  input wire host_bus_reset,
  input wire kept_regs_reset,
  input wire mac_if_reset,
  input wire mac_reset,
  input wire phy_reset,
  input wire eeprom_reload,
  input wire strap_latch,
  // read channel handshake
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // cycles since power-on release, frozen once the first reset drops
  reg [31:0] por_cnt;
  reg por_on;
  // counter instead of a long repetition, which tools unroll badly
  always @(posedge sys_clk) begin
    if (rst) begin
      por_cnt <= 32'h0;
      por_on <= 1'b1;
    end else if (por_on) begin
      por_cnt <= por_cnt + 32'h1;
      if (!pll_reset) por_on <= 1'b0;
    end
  end
  a_por_length: assert property (por_on && $fell(pll_reset) |->
    por_cnt >= POR_CYCLES - 1 && por_cnt <= POR_CYCLES + 4)
    else $error("power-on reset length wrong");
  a_full_group: assert property (pll_reset |-> kept_regs_reset && host_bus_reset &&
    mac_if_reset && mac_reset && phy_reset)
    else $error("full reset misses a block");
  a_kept_pll: assert property (kept_regs_reset == pll_reset)
    else $error("kept registers reset apart from pll");
  a_soft_group: assert property (host_bus_reset == mac_reset &&
    mac_reset == mac_if_reset)
    else $error("bus and mac resets disagree");
  a_soft_no_strap: assert property ($fell(host_bus_reset) &&
    !$past(kept_regs_reset) |-> !strap_latch ##1 !strap_latch)
    else $error("straps latched after soft reset");
  a_phy_alone: assert property ($rose(phy_reset) && !pll_reset |-> !host_bus_reset)
    else $error("phy reset touched the bus");
  a_strap_reload: assert property (strap_latch |-> eeprom_reload)
    else $error("strap latch without eeprom reload");
  a_reload_single: assert property (eeprom_reload |=> !eeprom_reload)
    else $error("eeprom reload longer than one cycle");
  a_pin_assert: assert property (!hard_reset_pin_n [*7] |-> pll_reset)
    else $error("pin low without full reset");
  a_pin_hold: assert property ($rose(hard_reset_pin_n) && pll_reset |->
    pll_reset [*8])
    else $error("reset dropped too soon after pin release");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
endmodule
bind rss_reset_seq rss_chk #(.POR_CYCLES(POR_CYCLES)) u_chk (
  .sys_clk(sys_clk), .rst(rst), .hard_reset_pin_n(hard_reset_pin_n),
  .pll_reset(pll_reset), .host_bus_reset(host_bus_reset), .kept_regs_reset(kept_regs_reset),
  .mac_if_reset(mac_if_reset), .mac_reset(mac_reset), .phy_reset(phy_reset),
  .eeprom_reload(eeprom_reload), .strap_latch(strap_latch), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid));
